//--- core/etb_pkg.sv
// constants and types for the enhanced timer channel b block
// Contract
// - mode field: compare, capture, pwm, timer
// - compare match: none, low, high, toggle
// - pwm: inactive, active, waveform, single pulse
// - capture: rising, falling, both, disabled
// - requested level equal initial gives no change
// - timer on rising restores initial pin level
// - output level sets initial or active level
// - invert bit inverts pin output
// - alignment: edge or centre up/down/both
// - counter readable as low byte, high bits
// - compare a value readable and writable
// - compare b value readable and writable
// - unused high register bits read zero
// - timer on rise restarts counter, fall holds
// - clear select: compare a or period/overflow
package etb_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHB_CTRL = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_CMPB_LO = 8'h18;
  localparam logic [7:0] OFS_CMPB_HI = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TC_ON = 0;
  localparam int TC_CLRSEL = 1;
  localparam int TC_PER_LO = 2;
  localparam int CB_MODE_LO = 6;
  localparam int CB_FUNC_LO = 4;
  localparam int CB_LEVEL = 3;
  localparam int CB_INV = 2;
  localparam int CB_ALIGN_LO = 0;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_P = 2;
  localparam int IRQ_CAP = 3;
  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;
  localparam int CLK_HZ = 25000000;
  localparam int COUNT_HZ = 6250000;
  localparam int COUNT_DIV = CLK_HZ / COUNT_HZ;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } etb_mode_t;
  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00,
    ALIGN_UP = 2'b01,
    ALIGN_DOWN = 2'b10,
    ALIGN_BOTH = 2'b11
  } etb_align_t;
endpackage

//--- core/etb_cnt_if.sv
// carrier between the register side and the counter core
`timescale 1ns/10ps
interface etb_cnt_if;
  logic tick;
  logic run;
  logic restart;
  logic clearSel;
  logic centre;
  logic [2:0] periodBits;
  logic [9:0] cmpA;
  logic [9:0] cmpB;
  logic [9:0] count;
  logic countDown;
  logic matchA;
  logic matchB;
  logic matchP;
  modport ctl (
    output tick, run, restart, clearSel, centre, periodBits, cmpA, cmpB,
    input count, countDown, matchA, matchB, matchP
  );
  modport core (
    input tick, run, restart, clearSel, centre, periodBits, cmpA, cmpB,
    output count, countDown, matchA, matchB, matchP
  );
endinterface

//--- core/etb_counter.sv
// ten-bit counter with compare a, compare b and period comparators
`timescale 1ns/10ps
module etb_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // counter carrier
  etb_cnt_if.core cnt
);
  logic [9:0] countQ;
  logic [9:0] countD;
  logic downQ;
  logic downD;
  logic [9:0] topP;
  logic [9:0] top;
  logic atTop;

  // period top: one below a multiple of 128, zero wraps to full range
  assign topP = {cnt.periodBits, 7'h00} - 10'h001;
  assign top = cnt.clearSel ? cnt.cmpA : topP;
  assign atTop = (countQ == top);
  assign cnt.matchA = cnt.tick && cnt.run && (countQ == cnt.cmpA);
  assign cnt.matchB = cnt.tick && cnt.run && (countQ == cnt.cmpB);
  assign cnt.matchP = cnt.tick && cnt.run && !cnt.clearSel && (countQ == topP);
  assign cnt.count = countQ;
  assign cnt.countDown = downQ;

  // next count: edge mode clears at top, centre mode reverses
  always_comb begin
    countD = countQ;
    downD = downQ;
    if (cnt.restart) begin
      countD = 10'h000;
      downD = 1'b0;
    end else if (cnt.tick && cnt.run) begin
      if (cnt.centre) begin
        if (!downQ && atTop) begin
          downD = 1'b1;
          countD = countQ - 10'h001;
        end else if (downQ && countQ == 10'h000) begin
          downD = 1'b0;
          countD = 10'h001;
        end else if (downQ) begin
          countD = countQ - 10'h001;
        end else begin
          countD = countQ + 10'h001;
        end
      end else begin
        countD = atTop ? 10'h000 : countQ + 10'h001;
        downD = 1'b0;
      end
    end
  end

  // counter state; holds while stopped
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      countQ <= 10'h000;
      downQ <= 1'b0;
    end else begin
      countQ <= countD;
      downQ <= downD;
    end
  end
endmodule

//--- core/etb_top.sv
// enhanced timer channel b: registers, pin logic, capture, interrupt
`timescale 1ns/10ps
module etb_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel b pins
  input wire logic [2:0] channelBPinIn,
  output logic [2:0] channelBPinOut,
  output logic [2:0] channelBPinOe,
  // interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstSync1Q;
  logic rstSync2Q;
  logic rstN;

  // two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1Q <= 1'b0;
      rstSync2Q <= 1'b0;
    end else begin
      rstSync1Q <= 1'b1;
      rstSync2Q <= rstSync1Q;
    end
  end
  assign rstN = rstSync2Q;

  // ------------------------------------------------------------
  // registers and counter core
  // ------------------------------------------------------------
  logic [7:0] timerCtrlQ;
  logic [7:0] chbCtrlQ;
  logic [9:0] cmpAQ;
  logic [9:0] cmpBQ;
  logic [3:0] irqStatQ;
  logic [3:0] irqMaskQ;
  logic timerOnPrevQ;
  logic [1:0] divQ;
  logic outQ;
  logic pinInPrevQ;
  etb_cnt_if cnt ();

  etb_counter u_counter (
    .clk(ref_clk),
    .rstN(rstN),
    .cnt(cnt)
  );

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic timerOn;
  logic onRise;
  logic [1:0] mode;
  logic [1:0] func;
  logic [1:0] align;
  logic level;
  logic invert;
  logic isCompare;
  logic isCapture;
  logic isPwm;
  logic isTimer;

  // control fields and mode decode
  assign timerOn = timerCtrlQ[etb_pkg::TC_ON];
  assign onRise = timerOn && !timerOnPrevQ;
  assign mode = chbCtrlQ[etb_pkg::CB_MODE_LO +: 2];
  assign func = chbCtrlQ[etb_pkg::CB_FUNC_LO +: 2];
  assign align = chbCtrlQ[etb_pkg::CB_ALIGN_LO +: 2];
  assign level = chbCtrlQ[etb_pkg::CB_LEVEL];
  assign invert = chbCtrlQ[etb_pkg::CB_INV];
  assign isCompare = (mode == etb_pkg::MODE_COMPARE);
  assign isCapture = (mode == etb_pkg::MODE_CAPTURE);
  assign isPwm = (mode == etb_pkg::MODE_PWM);
  assign isTimer = (mode == etb_pkg::MODE_TIMER);

  // counter carrier drive
  assign cnt.tick = (divQ == 2'(etb_pkg::COUNT_DIV - 1));
  assign cnt.run = timerOn;
  assign cnt.restart = onRise;
  assign cnt.clearSel = timerCtrlQ[etb_pkg::TC_CLRSEL];
  assign cnt.periodBits = timerCtrlQ[etb_pkg::TC_PER_LO +: 3];
  assign cnt.centre = isPwm && (align != etb_pkg::ALIGN_EDGE);
  assign cnt.cmpA = cmpAQ;
  assign cnt.cmpB = cmpBQ;

  // count-rate divider
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      divQ <= 2'h0;
    end else begin
      divQ <= cnt.tick ? 2'h0 : divQ + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // channel b output state
  // ------------------------------------------------------------
  logic outD;
  logic bMatchUp;
  logic bMatchDown;

  // centre-aligned match qualification by direction
  // alignment selects match direction
  assign bMatchUp = cnt.matchB && !cnt.countDown &&
                    (align == etb_pkg::ALIGN_UP || align == etb_pkg::ALIGN_BOTH);
  assign bMatchDown = cnt.matchB && cnt.countDown &&
                      (align == etb_pkg::ALIGN_DOWN || align == etb_pkg::ALIGN_BOTH);

  // outD is the pre-polarity pin level; pwm state 1 means active
  always_comb begin
    outD = outQ;
    if (isCompare) begin
      if (onRise) begin
        outD = level;
      end else if (cnt.matchB) begin
        // match action; equal level shows no change
        case (func)
          2'b01: outD = 1'b0;
          2'b10: outD = 1'b1;
          2'b11: outD = ~outQ;
          default: outD = outQ;
        endcase
      end
    end else if (isPwm) begin
      case (func)
        2'b00: outD = 1'b0;
        2'b01: outD = 1'b1;
        2'b10: begin
          if (onRise) begin
            outD = 1'b1;
          end else if (align == etb_pkg::ALIGN_EDGE) begin
            if (cnt.tick && cnt.run && cnt.count == 10'h000) outD = 1'b1;
            if (cnt.matchB) outD = 1'b0;
          end else begin
            if (bMatchUp) outD = 1'b0;
            if (bMatchDown) outD = 1'b1;
          end
        end
        default: begin
          // single pulse: active from start until compare b match
          if (onRise) outD = 1'b1;
          else if (cnt.matchB) outD = 1'b0;
        end
      endcase
    end
  end

  // output state register and on-bit history
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      outQ <= 1'b0;
      timerOnPrevQ <= 1'b0;
    end else begin
      outQ <= outD;
      timerOnPrevQ <= timerOn;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  logic pinLevel;
  logic pinFinal;

  // pwm active level chosen by the level bit
  assign pinLevel = isPwm ? (outQ ? level : ~level) : outQ;
  assign pinFinal = pinLevel ^ invert;
  // pins driven only in compare and pwm modes
  assign channelBPinOut = {3{pinFinal}};
  assign channelBPinOe = {3{isCompare || isPwm}};

  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  logic pinIn;
  logic capEdge;

  assign pinIn = channelBPinIn[0];
  assign capEdge = isCapture && timerOn && (
                   (func == 2'b00 && pinIn && !pinInPrevQ) ||
                   (func == 2'b01 && !pinIn && pinInPrevQ) ||
                   (func == 2'b10 && pinIn != pinInPrevQ));

  // previous pin sample for edge detection
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pinInPrevQ <= 1'b0;
    end else begin
      pinInPrevQ <= pinIn;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic awHeldQ;
  logic wHeldQ;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic wrLane0;
  logic [7:0] wByte;
  logic wrMapped;
  logic rdMapped;
  logic [7:0] rdByte;
  logic [3:0] irqEvents;

  // write channels taken separately, write done once both held
  assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
  assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  assign wrLane0 = doWrite && wStrbQ[0];
  assign wByte = wDataQ[7:0];
  assign wrMapped = (awAddrQ[1:0] == 2'b00) && (awAddrQ <= etb_pkg::OFS_IRQ_MASK);
  assign s_axi_arready = !s_axi_rvalid;
  assign rdMapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= etb_pkg::OFS_IRQ_MASK);

  // read mux
  always_comb begin
    case (s_axi_araddr)
      etb_pkg::OFS_TIMER_CTRL: rdByte = timerCtrlQ;
      etb_pkg::OFS_CHB_CTRL: rdByte = chbCtrlQ;
      etb_pkg::OFS_CNT_LO: rdByte = cnt.count[7:0];
      etb_pkg::OFS_CNT_HI: rdByte = {6'h00, cnt.count[9:8]};
      etb_pkg::OFS_CMPA_LO: rdByte = cmpAQ[7:0];
      etb_pkg::OFS_CMPA_HI: rdByte = {6'h00, cmpAQ[9:8]};
      etb_pkg::OFS_CMPB_LO: rdByte = cmpBQ[7:0];
      etb_pkg::OFS_CMPB_HI: rdByte = {6'h00, cmpBQ[9:8]};
      etb_pkg::OFS_IRQ_STAT: rdByte = {4'h0, irqStatQ};
      etb_pkg::OFS_IRQ_MASK: rdByte = {4'h0, irqMaskQ};
      default: rdByte = 8'h00;
    endcase
  end

  // bus handshake state
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= etb_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= etb_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? etb_pkg::RESP_OKAY : etb_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rdByte};
        s_axi_rresp <= rdMapped ? etb_pkg::RESP_OKAY : etb_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control register writes
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      timerCtrlQ <= etb_pkg::RST_BYTE;
      chbCtrlQ <= etb_pkg::RST_BYTE;
      irqMaskQ <= etb_pkg::RST_IRQ;
    end else if (wrLane0) begin
      if (awAddrQ == etb_pkg::OFS_TIMER_CTRL) timerCtrlQ <= {3'h0, wByte[4:0]};
      if (awAddrQ == etb_pkg::OFS_CHB_CTRL) chbCtrlQ <= wByte;
      if (awAddrQ == etb_pkg::OFS_IRQ_MASK) irqMaskQ <= wByte[3:0];
    end
  end

  // compare values; capture loads compare b and beats a same-cycle write
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cmpAQ <= 10'h000;
      cmpBQ <= 10'h000;
    end else begin
      if (wrLane0 && awAddrQ == etb_pkg::OFS_CMPA_LO) cmpAQ[7:0] <= wByte;
      if (wrLane0 && awAddrQ == etb_pkg::OFS_CMPA_HI) cmpAQ[9:8] <= wByte[1:0];
      if (wrLane0 && awAddrQ == etb_pkg::OFS_CMPB_LO) cmpBQ[7:0] <= wByte;
      if (wrLane0 && awAddrQ == etb_pkg::OFS_CMPB_HI) cmpBQ[9:8] <= wByte[1:0];
      // captured count lands in compare b
      if (capEdge) cmpBQ <= cnt.count;
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  assign irqEvents = {capEdge, cnt.matchP, cnt.matchB, cnt.matchA};

  // sticky status, write one to clear, new event wins
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      irqStatQ <= etb_pkg::RST_IRQ;
    end else if (wrLane0 && awAddrQ == etb_pkg::OFS_IRQ_STAT) begin
      irqStatQ <= (irqStatQ & ~wByte[3:0]) | irqEvents;
    end else begin
      irqStatQ <= irqStatQ | irqEvents;
    end
  end
  assign irq = |(irqStatQ & irqMaskQ);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence onRiseSeq;
    !timerOn ##1 timerOn;
  endsequence

  counter_restart_a: assert property (onRiseSeq |=> cnt.count == 10'h000)
    else $error("counter not restarted on timer start");
  counter_hold_a: assert property (!timerOn && !$past(timerOn) |=> $stable(cnt.count))
    else $error("counter moved while timer off");
  pin_initial_a: assert property (onRiseSeq ##0 isCompare |=> outQ == $past(level))
    else $error("pin not returned to initial level");
  match_low_a: assert property (isCompare && cnt.matchB && func == 2'b01 && !onRise
    |=> !outQ)
    else $error("compare match did not drive low");
  match_toggle_a: assert property (isCompare && cnt.matchB && func == 2'b11 && !onRise
    |=> outQ != $past(outQ))
    else $error("compare match did not toggle");
  pwm_force_a: assert property (isPwm && func == 2'b01 ##1 isPwm && func == 2'b01
    |-> pinFinal == (level ^ invert))
    else $error("forced active level wrong");
  pin_enable_a: assert property (isTimer || isCapture |-> channelBPinOe == 3'b000)
    else $error("pin driven in timer or capture mode");
  capture_load_a: assert property (capEdge |=> cmpBQ == $past(cnt.count))
    else $error("capture did not load compare b");
  high_zero_a: assert property (s_axi_rvalid && s_axi_rresp == etb_pkg::RESP_OKAY
    |-> s_axi_rdata[31:10] == 22'h000000)
    else $error("upper read bits not zero");
  clear_sel_a: assert property (cnt.clearSel && !cnt.centre && cnt.matchA && !onRise
    |=> cnt.count == 10'h000)
    else $error("compare a match did not clear counter");
  status_set_a: assert property (cnt.matchB |=> irqStatQ[etb_pkg::IRQ_B])
    else $error("compare b event lost");
endmodule

//--- verif/tb_enhanced_timer_channel_b_ctrl.sv
// self-checking testbench for the enhanced timer channel b block
`timescale 1ns/10ps
module tb_enhanced_timer_channel_b_ctrl;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [2:0] channelBPinIn = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdData;
  logic [1:0] rdResp;
  logic [2:0] channelBPinOut, channelBPinOe;
  int nFail = 0;
  int cmpCount = 0;

  etb_top etb_top_inst (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .channelBPinIn, .channelBPinOut, .channelBPinOe, .irq);

  // 25 mhz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // pins, enables and interrupt, sampled mid-cycle where settled
  task automatic chkPins(input logic [2:0] o, input logic [2:0] e, input logic q);
    @(negedge ref_clk);
    chk32({25'h0, channelBPinOut, channelBPinOe, irq}, {25'h0, o, e, q});
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w) && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    s_axi_bready <= 1'b0;
    if (n >= 100) nFail++;
  endtask

  // read: result lands in rdData and rdResp
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_arready && n < 100);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    rdData = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) nFail++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk32(rdData, e);
  endtask

  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    finishTest();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int i;
    logic ev;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 10; i++) rdc(8'(i * 4), 32'h0);
    chkPins(3'h0, 3'h7, 1'b0);
    rd(8'h28);
    chk32({30'h0, rdResp}, {30'h0, etb_pkg::RESP_SLVERR});
    // compare values keep ten bits, upper high bits read zero
    wr(etb_pkg::OFS_CMPA_LO, 32'hffff_ffa5);
    wr(etb_pkg::OFS_CMPA_HI, 32'hffff_ffff);
    rdc(etb_pkg::OFS_CMPA_LO, 32'ha5);
    rdc(etb_pkg::OFS_CMPA_HI, 32'h3);
    wr(etb_pkg::OFS_CMPB_LO, 32'h5a);
    wr(etb_pkg::OFS_CMPB_HI, 32'hfe);
    rdc(etb_pkg::OFS_CMPB_LO, 32'h5a);
    rdc(etb_pkg::OFS_CMPB_HI, 32'h2);
    wr(etb_pkg::OFS_CNT_LO, 32'h77);
    rdc(etb_pkg::OFS_CNT_LO, 32'h0);
    wr(etb_pkg::OFS_CMPB_LO, 32'h5);
    wr(etb_pkg::OFS_CMPB_HI, 32'h0);
    // compare mode: every function with both levels and inversions
    for (i = 0; i < 8; i++) begin
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
      wr(etb_pkg::OFS_CHB_CTRL, {24'h0, 2'b00, i[1:0], i[2], i[2] ^ i[0], 2'b00});
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      chkPins({3{i[0]}}, 3'h7, 1'b0);
      repeat (40) @(posedge ref_clk);
      ev = (i[1:0] == 2'b00) ? i[2] : (i[1:0] == 2'b11) ? ~i[2] : i[1];
      chkPins({3{ev ^ i[2] ^ i[0]}}, 3'h7, 1'b0);
    end
    // counter holds while off and restarts from zero when turned on
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
    rd(etb_pkg::OFS_CNT_LO);
    chk32(32'(rdData > 8 && rdData < 14), 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(etb_pkg::OFS_CNT_LO);
    chk32(32'(rdData > 8 && rdData < 14), 32'h1);
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
    rd(etb_pkg::OFS_CNT_LO);
    chk32(32'(rdData < 3), 32'h1);
    // clear on compare a keeps the count at or below it
    wr(etb_pkg::OFS_CMPA_LO, 32'h3);
    wr(etb_pkg::OFS_CMPA_HI, 32'h0);
    // restart with clear select so the count starts below compare a
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h3);
    repeat (30) @(posedge ref_clk);
    rd(etb_pkg::OFS_CNT_LO);
    chk32(32'(rdData < 4), 32'h1);
    // pwm functions, active high, edge aligned, duty ends at count 5
    for (i = 0; i < 4; i++) begin
      // pin function changed only while off
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
      wr(etb_pkg::OFS_CHB_CTRL, {24'h0, 2'b10, i[1:0], 4'b1000});
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      chkPins({3{i != 0}}, 3'h7, 1'b0);
      repeat (40) @(posedge ref_clk);
      chkPins({3{i == 1}}, 3'h7, 1'b0);
    end
    // centre aligned pwm, active low and inverted: up-only then down-only matches
    for (i = 1; i < 3; i++) begin
      // pin function changed only while off
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
      wr(etb_pkg::OFS_CHB_CTRL, {24'h0, 2'b10, 2'b10, 2'b01, i[1:0]});
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
      repeat (40) @(posedge ref_clk);
      chkPins({3{i == 2}}, 3'h7, 1'b0);
    end
    // timer mode releases the pins
    // timer off before mode change
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
    wr(etb_pkg::OFS_CHB_CTRL, 32'hc0);
    @(negedge ref_clk);
    chk32({29'h0, channelBPinOe}, 32'h0);
    // capture on each edge selection
    for (i = 0; i < 4; i++) begin
      wr(etb_pkg::OFS_CHB_CTRL, {24'h0, 2'b01, i[1:0], 4'h0});
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
      wr(etb_pkg::OFS_IRQ_STAT, 32'hf);
      channelBPinIn <= 3'h1;
      repeat (4) @(posedge ref_clk);
      rd(etb_pkg::OFS_IRQ_STAT);
      chk32(rdData & 32'h8, (i == 0 || i == 2) ? 32'h8 : 32'h0);
      wr(etb_pkg::OFS_IRQ_STAT, 32'h8);
      channelBPinIn <= 3'h0;
      repeat (4) @(posedge ref_clk);
      rd(etb_pkg::OFS_IRQ_STAT);
      chk32(rdData & 32'h8, (i == 1 || i == 2) ? 32'h8 : 32'h0);
      wr(etb_pkg::OFS_TIMER_CTRL, 32'h0);
    end
    // interrupt: masked, unmasked, then cleared
    wr(etb_pkg::OFS_CHB_CTRL, 32'h40);
    wr(etb_pkg::OFS_TIMER_CTRL, 32'h1);
    channelBPinIn <= 3'h1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk32({31'h0, irq}, 32'h0);
    wr(etb_pkg::OFS_IRQ_MASK, 32'h8);
    @(negedge ref_clk);
    chk32({31'h0, irq}, 32'h1);
    wr(etb_pkg::OFS_IRQ_STAT, 32'h8);
    @(negedge ref_clk);
    chk32({31'h0, irq}, 32'h0);
    rdc(etb_pkg::OFS_IRQ_MASK, 32'h8);
    finishTest();
  end
endmodule
